// >>> core/fes_event_status.sv
`timescale 1ns/1ns
// Framer event status, interrupt masks, link byte and E1 SSM logic over APB
// Functional notes
// - Mask three bits 0 to 7 gate link events; 1 enables, 0 masks.
// - E1 only: receive align-frame event every 250us at each align frame.
// - E1: CRC4 multiframe event on boundaries; free-running 2ms when CRC4 off.
// - E1: receive multiframe event every 2ms, independent of CAS.
// - T1: receive and transmit multiframe events every 1.5ms D4, 3ms ESF.
// - E1 only: transmit align-frame event every 250us at each align frame.
// - E1: transmit multiframe event every 2ms, independent of CRC4.
// - E1: signaling all-zeros event when time slot 16 zero whole multiframe.
// - E1: all-ones event, under three zeros in 16 frames, also in CCS.
// - Mask four bits 0 to 6 enable status four events; bit 7 zero.
// - Transmit link byte sent into T1 stream, bit 0 first, bit 7 last.
// - D4 mode takes its Fs pattern bits from the transmit link byte.
// - Four-bit SSM codes: unknown, PRS, SSU-A, SSU-B, SETS, do-not-use.
// - E1 message rides in exactly one selectable Sa4 to Sa8 position.
// - Message MSB first from first odd frame of each sub-multiframe, two per MF.
// - Received message valid only after three equal sub-multiframes.
// - Sa access aligned to CRC4 multiframe, or alternately to double frames.
module fes_event_status (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fes_pkg::FES_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Framer timing and link events
  input wire fes_pkg::fes_rx_frame_type rxFrame,
  input wire fes_pkg::fes_tx_frame_type txFrame,
  input wire logic [7:0] linkEvents,
  // Line side and interrupt
  output logic txLinkBit,
  output logic txSaBit,
  output logic [4:0] txSaSelect,
  output logic irq
);
  import fes_pkg::*;

  typedef struct packed {
    logic [7:0] stat3;
    logic [7:0] mask3;
    logic [7:0] stat4;
    logic [7:0] mask4;
    logic [7:0] txLink;
    fes_ctrl_type ctrl;
    logic [3:0] ssmTx;
    logic [4:0] saRaw;
    logic [4:0] rxFrm;
    logic [4:0] txFrm;
    logic [3:0] crcFrm;
    logic [3:0] onesFrm;
    logic [3:0] zeroCnt;
    logic allZero;
    logic [3:0] rxSsm;
    logic [3:0] txSsm;
    logic txSaBit;
    logic [4:0] saSelect;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } fes_state_type;

  localparam fes_state_type STATE_RESET = '{
    stat3: FES_REG_RESET, mask3: FES_REG_RESET, stat4: FES_REG_RESET,
    mask4: FES_REG_RESET, txLink: FES_REG_RESET, ctrl: FES_REG_RESET,
    ssmTx: FES_SSMTX_RESET, default: '0};

  fes_state_type s_q;
  fes_state_type s_d;
  logic codeStrobe;
  logic [3:0] rxCode;
  logic [3:0] ssmCode;
  logic ssmValid;
  logic linkBitReq;

  // One-hot Sa4..Sa8 position; out-of-range selections fall back to Sa4
  function automatic logic [4:0] saOneHot(input logic [2:0] sel);
    logic [4:0] hot;
    hot = 5'h01;
    if (sel == 3'h1) begin
      hot = 5'h02;
    end else if (sel == 3'h2) begin
      hot = 5'h04;
    end else if (sel == 3'h3) begin
      hot = 5'h08;
    end else if (sel == 3'h4) begin
      hot = 5'h10;
    end
    return hot;
  endfunction : saOneHot

  // Number of zero bits in one time slot byte
  function automatic logic [3:0] zeroCount(input logic [7:0] b);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, ~b[i]};
    end
    return n;
  endfunction : zeroCount

  // Frames per multiframe for the current line mode
  function automatic logic [4:0] mfLength(input fes_ctrl_type c);
    logic [4:0] len;
    len = FES_D4_MF_FRAMES;
    if (c.e1) begin
      len = FES_E1_MF_FRAMES;
    end else if (c.esf) begin
      len = FES_ESF_MF_FRAMES;
    end
    return len;
  endfunction : mfLength

  // Next frame index: restart on the framer's boundary, else wrap at length
  function automatic logic [4:0] nextFrame(input logic [4:0] cur, input logic sync,
                                           input logic [4:0] len);
    logic [4:0] nxt;
    nxt = cur + 5'h01;
    if (sync || cur >= len - 5'h01) begin
      nxt = 5'h00;
    end
    return nxt;
  endfunction : nextFrame

  // Main next-state logic
  always_comb begin
    logic [7:0] idx;
    logic setup;
    logic access;
    logic [4:0] len;
    logic [4:0] rxIdx;
    logic [4:0] txIdx;
    logic [3:0] crcIdx;
    logic [7:0] ev4;
    logic [7:0] clr3;
    logic [7:0] clr4;
    logic [3:0] zeros;
    logic zAll;
    logic rxSel;
    logic fs;
    logic [31:0] rd;
    logic err;
    s_d = s_q;
    idx = paddr[FES_ADDR_W-1:2];
    setup = psel && !penable;
    access = psel && penable && s_q.pready;
    len = mfLength(s_q.ctrl);
    fs = rxFrame.frameStart;
    rxIdx = s_q.rxFrm;
    txIdx = s_q.txFrm;
    crcIdx = s_q.crcFrm;
    ev4 = 8'h00;
    clr3 = 8'h00;
    clr4 = 8'h00;
    zeros = 4'h0;
    zAll = 1'b0;
    rxSel = |(saOneHot(s_q.ctrl.saSel) & rxFrame.saBits);
    rd = 32'h0000_0000;
    err = 1'b0;
    codeStrobe = 1'b0;
    rxCode = {s_q.rxSsm[2:0], rxSel};

    // Receive frame counters; CRC4 boundary runs free when CRC4 is off
    if (fs) begin
      rxIdx = nextFrame(s_q.rxFrm, rxFrame.mfStart, len);
      crcIdx = s_q.crcFrm + 4'h1;
      if (rxFrame.mfStart && s_q.ctrl.crc4) begin
        crcIdx = 4'h0;
      end
      s_d.rxFrm = rxIdx;
      s_d.crcFrm = crcIdx;
      s_d.onesFrm = s_q.onesFrm + 4'h1;
    end
    if (txFrame.frameStart) begin
      txIdx = nextFrame(s_q.txFrm, txFrame.mfStart, len);
      s_d.txFrm = txIdx;
    end

    // Frame timing events
    ev4[0] = fs && s_q.ctrl.e1 && (rxIdx % FES_ALIGN_FRAMES) == 5'h00;
    ev4[1] = fs && s_q.ctrl.e1 && crcIdx == 4'h0;
    ev4[2] = fs && rxIdx == 5'h00;
    ev4[3] = txFrame.frameStart && s_q.ctrl.e1
             && (txIdx % FES_ALIGN_FRAMES) == 5'h00;
    ev4[4] = txFrame.frameStart && txIdx == 5'h00;

    // Time slot 16 all-zeros over a multiframe
    zAll = (rxIdx == 5'h00 || s_q.allZero) && rxFrame.ts16 == 8'h00;
    if (fs) begin
      s_d.allZero = zAll;
    end
    ev4[5] = fs && s_q.ctrl.e1 && zAll && rxIdx == len - 5'h01;

    // Zeros counted over each 16-frame window, saturating past the threshold
    zeros = zeroCount(rxFrame.ts16);
    if (s_q.onesFrm != 4'h0) begin
      zeros = zeros + s_q.zeroCnt;
    end
    if (zeros > FES_ONES_MIN_ZEROS) begin
      zeros = FES_ONES_MIN_ZEROS;
    end
    if (fs) begin
      s_d.zeroCnt = zeros;
    end
    // Not gated by any signaling mode, so CCS keeps the alarm alive
    ev4[6] = fs && s_q.ctrl.e1 && s_q.onesFrm == FES_ONES_WINDOW_LAST
             && zeros < FES_ONES_MIN_ZEROS;

    // Received message bits in odd frames of each sub-multiframe
    if (fs && s_q.ctrl.e1 && crcIdx[0]) begin
      s_d.rxSsm = rxCode;
      codeStrobe = crcIdx[2:0] == FES_SMF_LAST;
    end

    // Raw Sa snapshot per CRC4 multiframe or per double frame
    if (fs && crcIdx[0] && (s_q.ctrl.dblAccess || crcIdx == 4'hF)) begin
      s_d.saRaw = rxFrame.saBits;
    end

    // Transmit message loads per sub-multiframe, MSB in its first odd frame
    if (txFrame.frameStart && s_q.ctrl.e1) begin
      if (txIdx[2:0] == 3'h0) begin
        s_d.txSsm = s_q.ssmTx;
      end else if (txIdx[0]) begin
        s_d.txSaBit = s_q.txSsm[3];
        s_d.txSsm = {s_q.txSsm[2:0], 1'b0};
      end
    end
    s_d.saSelect = saOneHot(s_q.ctrl.saSel);

    // APB setup: answer is prepared here and shown through the access phase
    s_d.pready = setup;
    s_d.pslverr = 1'b0; // Error stands only beside ready
    if (setup) begin
      if (idx == FES_IDX_STAT3) begin
        rd[7:0] = s_q.stat3;
      end else if (idx == FES_IDX_MASK3) begin
        rd[7:0] = s_q.mask3;
      end else if (idx == FES_IDX_STAT4) begin
        rd[7:0] = s_q.stat4;
      end else if (idx == FES_IDX_MASK4) begin
        rd[7:0] = s_q.mask4;
      end else if (idx == FES_IDX_TXLINK) begin
        rd[7:0] = s_q.txLink;
      end else if (idx == FES_IDX_CTRL) begin
        rd[7:0] = s_q.ctrl;
      end else if (idx == FES_IDX_SSMTX) begin
        rd[3:0] = s_q.ssmTx;
      end else if (idx == FES_IDX_SSMRX) begin
        rd[3:0] = ssmCode;
        rd[FES_SSMRX_VALID_BIT] = ssmValid;
        rd[FES_SSMRX_RAW_LSB+:5] = s_q.saRaw;
      end else begin
        err = 1'b1;
      end
      s_d.prdata = rd;
      s_d.pslverr = err;
    end

    // APB access: writes land and read-clears act at the completing edge
    if (access && !s_q.pslverr) begin
      if (pwrite) begin
        if (idx == FES_IDX_MASK3) begin
          s_d.mask3 = pwdata[7:0];
        end else if (idx == FES_IDX_MASK4) begin
          s_d.mask4 = pwdata[7:0] & FES_MASK4_WMASK;
        end else if (idx == FES_IDX_TXLINK) begin
          s_d.txLink = pwdata[7:0];
        end else if (idx == FES_IDX_CTRL) begin
          s_d.ctrl = pwdata[7:0];
        end else if (idx == FES_IDX_SSMTX) begin
          s_d.ssmTx = pwdata[3:0];
        end
      end else if (idx == FES_IDX_STAT3) begin
        clr3 = s_q.prdata[7:0];
      end else if (idx == FES_IDX_STAT4) begin
        clr4 = s_q.prdata[7:0];
      end
    end

    // Only bits already reported are cleared, and a new event wins the clear
    s_d.stat3 = (s_q.stat3 & ~clr3) | linkEvents;
    s_d.stat4 = (s_q.stat4 & ~clr4) | ev4;
    s_d.irq = |((s_d.stat3 & s_d.mask3) | (s_d.stat4 & s_d.mask4));
  end

  // The link byte only feeds a T1 stream
  assign linkBitReq = txFrame.linkBitReq && !s_q.ctrl.e1;

  // Link byte serializer
  fes_link_serializer u_link (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .linkByte(s_q.txLink),
    .bitReq(linkBitReq),
    .txBit(txLinkBit)
  );

  // Received message validator
  fes_ssm_validator u_ssm (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .codeStrobe(codeStrobe),
    .code(rxCode),
    .validCode(ssmCode),
    .valid(ssmValid)
  );

  // State register; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= STATE_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Registered outputs
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign txSaBit = s_q.txSaBit;
  assign txSaSelect = s_q.saSelect;
  assign irq = s_q.irq;

endmodule : fes_event_status

// >>> core/fes_link_serializer.sv
`timescale 1ns/1ns
// Serializer that sends the transmit link byte least significant bit first
module fes_link_serializer (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Byte source and bit request
  input wire logic [7:0] linkByte,
  input wire logic bitReq,
  // Serial output
  output logic txBit
);
  import fes_pkg::*;

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] left;
    logic txBit;
  } fes_ser_state_type;

  fes_ser_state_type s_q;
  fes_ser_state_type s_d;

  // Byte reloads only after its last bit, so a write mid-byte waits its turn
  always_comb begin
    s_d = s_q;
    if (bitReq) begin
      if (s_q.left == 3'h0) begin
        s_d.txBit = linkByte[0];
        s_d.shift = {1'b0, linkByte[7:1]};
        s_d.left = 3'h7;
      end else begin
        s_d.txBit = s_q.shift[0];
        s_d.shift = {1'b0, s_q.shift[7:1]};
        s_d.left = s_q.left - 3'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign txBit = s_q.txBit;

endmodule : fes_link_serializer

// >>> core/fes_pkg.sv
// Shared constants and carrier types for the framer event status block
package fes_pkg;

  // Frame timing in microseconds and the frame counts derived from it
  localparam int unsigned FES_FRAME_US = 125;
  localparam int unsigned FES_ALIGN_US = 250;
  localparam int unsigned FES_E1_MF_US = 2000;
  localparam int unsigned FES_D4_MF_US = 1500;
  localparam int unsigned FES_ESF_MF_US = 3000;
  localparam logic [4:0] FES_ALIGN_FRAMES = 5'(FES_ALIGN_US / FES_FRAME_US);
  localparam logic [4:0] FES_E1_MF_FRAMES = 5'(FES_E1_MF_US / FES_FRAME_US);
  localparam logic [4:0] FES_D4_MF_FRAMES = 5'(FES_D4_MF_US / FES_FRAME_US);
  localparam logic [4:0] FES_ESF_MF_FRAMES = 5'(FES_ESF_MF_US / FES_FRAME_US);

  // Signaling alarm and message validation figures
  localparam logic [3:0] FES_ONES_WINDOW_LAST = 4'hF;
  localparam logic [3:0] FES_ONES_MIN_ZEROS = 4'h3;
  localparam logic [1:0] FES_SSM_REPEAT = 2'h3;
  localparam logic [2:0] FES_SMF_LAST = 3'h7;

  // Synchronization status message codes
  localparam logic [3:0] FES_SSM_UNKNOWN = 4'h0;
  localparam logic [3:0] FES_SSM_PRS = 4'h2;
  localparam logic [3:0] FES_SSM_SSUA = 4'h4;
  localparam logic [3:0] FES_SSM_SSUB = 4'h8;
  localparam logic [3:0] FES_SSM_SETS = 4'hB;
  localparam logic [3:0] FES_SSM_DNU = 4'hF;

  // Register indices; the byte address is four times the index
  localparam int unsigned FES_ADDR_W = 10;
  localparam logic [7:0] FES_IDX_STAT3 = 8'h18;
  localparam logic [7:0] FES_IDX_MASK3 = 8'h19;
  localparam logic [7:0] FES_IDX_STAT4 = 8'h1A;
  localparam logic [7:0] FES_IDX_MASK4 = 8'h1B;
  localparam logic [7:0] FES_IDX_TXLINK = 8'h51;
  localparam logic [7:0] FES_IDX_CTRL = 8'h60;
  localparam logic [7:0] FES_IDX_SSMTX = 8'h61;
  localparam logic [7:0] FES_IDX_SSMRX = 8'h62;

  // Reset values, writable bits and read field positions
  localparam logic [7:0] FES_REG_RESET = 8'h00;
  localparam logic [7:0] FES_MASK4_WMASK = 8'h7F;
  localparam logic [3:0] FES_SSMTX_RESET = FES_SSM_UNKNOWN;
  localparam int unsigned FES_SSMRX_VALID_BIT = 4;
  localparam int unsigned FES_SSMRX_RAW_LSB = 8;

  // Control register layout
  typedef struct packed {
    logic spare;
    logic [2:0] saSel;
    logic dblAccess;
    logic esf;
    logic crc4;
    logic e1;
  } fes_ctrl_type;

  // Receive frame strobe with the data that travels with it
  typedef struct packed {
    logic frameStart;
    logic mfStart;
    logic [7:0] ts16;
    logic [4:0] saBits;
  } fes_rx_frame_type;

  // Transmit frame strobes
  typedef struct packed {
    logic frameStart;
    logic mfStart;
    logic linkBitReq;
  } fes_tx_frame_type;

endpackage : fes_pkg

// >>> core/fes_ssm_validator.sv
`timescale 1ns/1ns
// Validator that accepts a status message after three equal sub-multiframes
module fes_ssm_validator (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Received code, one strobe per sub-multiframe
  input wire logic codeStrobe,
  input wire logic [3:0] code,
  // Validated code
  output logic [3:0] validCode,
  output logic valid
);
  import fes_pkg::*;

  typedef struct packed {
    logic [3:0] last;
    logic [1:0] repeats;
    logic [3:0] vcode;
    logic valid;
  } fes_val_state_type;

  fes_val_state_type s_q;
  fes_val_state_type s_d;

  // Count equal codes; a change restarts the run but keeps the old valid code
  always_comb begin
    s_d = s_q;
    if (codeStrobe) begin
      if (code == s_q.last && s_q.repeats != 2'h0) begin
        if (s_q.repeats != FES_SSM_REPEAT) begin
          s_d.repeats = s_q.repeats + 2'h1;
        end
      end else begin
        s_d.last = code;
        s_d.repeats = 2'h1;
      end
      if (s_d.repeats == FES_SSM_REPEAT) begin
        s_d.vcode = code;
        s_d.valid = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign validCode = s_q.vcode;
  assign valid = s_q.valid;

endmodule : fes_ssm_validator

// >>> test/fes_event_status_props.sv
// Port-level assertions for the framer event status block
`timescale 1ns/1ns
module fes_event_status_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fes_pkg::FES_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Framer side
  input wire fes_pkg::fes_rx_frame_type rxFrame,
  input wire fes_pkg::fes_tx_frame_type txFrame,
  input wire logic [7:0] linkEvents,
  input wire logic txLinkBit,
  input wire logic irq
);
  import fes_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [7:0] linkByte_q;
  logic [2:0] bitIdx_q;
  logic expBit;
  logic done;
  logic cause;
  logic linkReq;
  logic mask4Rd;
  assign linkReq = ce && txFrame.linkBitReq;
  assign mask4Rd = pready && !pwrite && paddr[9:2] == FES_IDX_MASK4;
  assign done = psel && penable && pready && ce;
  assign cause = rxFrame.frameStart || txFrame.frameStart || (|linkEvents) || (done && pwrite);
  assign expBit = linkByte_q[bitIdx_q];
  // Shadow of the link byte; a rewrite restarts the bit count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linkByte_q <= 8'h00;
      bitIdx_q <= 3'h0;
    end else if (done && pwrite && paddr[9:2] == FES_IDX_TXLINK) begin
      linkByte_q <= pwdata[7:0];
      bitIdx_q <= 3'h0;
    end else if (ce && txFrame.linkBitReq) begin
      bitIdx_q <= bitIdx_q + 3'h1;
    end
  end
  sequence setupSeq;
    psel && !penable && ce;
  endsequence
  sequence finishSeq;
    done;
  endsequence
  chk_ready_after_setup: assert property (setupSeq |=> pready)
    else $error("no ready one cycle after setup");
  chk_ready_single: assert property (finishSeq |=> !pready)
    else $error("ready stood past access");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("error read data not zero");
  chk_mask_top_zero: assert property (mask4Rd |-> !prdata[7])
    else $error("mask four top bit set");
  chk_irq_rise_cause: assert property ($rose(irq) |-> $past(cause))
    else $error("irq rose without event or write");
  chk_irq_fall_cause: assert property ($fell(irq) |-> $past(done))
    else $error("irq fell without host access");
  chk_link_bit_order: assert property (linkReq |=> txLinkBit == $past(expBit))
    else $error("link bit out of order");
endmodule : fes_event_status_props

// >>> test/fes_host_model.sv
// Host processor model speaking APB to the status block
`timescale 1ns/1ns
module fes_host_model (
  // Clock
  input wire logic clk,
  // APB request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [fes_pkg::FES_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  // APB answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end
  // One transfer; reads come promptly after each event, well inside the window
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Pre-edge ready decides; a dead slave is left to the bench watchdog
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : fes_host_model

// >>> test/tb_top.sv
// Self-checking bench for the framer event status block
`timescale 1ns/1ns
module tb_top;
  import fes_pkg::*;
  logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr;
  logic [FES_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  fes_rx_frame_type rxFrame;
  fes_tx_frame_type txFrame;
  logic [7:0] linkEvents;
  logic txLinkBit, txSaBit, irq;
  logic [4:0] txSaSelect;
  int fail_count, total_checks, expStat3, expStat4, mask3, mask4, idx, mfLen, winZeros;
  logic e1, zeroMf;
  logic [3:0] ssmRx;
  logic [31:0] seed;
  fes_event_status dut (.clk(clk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxFrame(rxFrame), .txFrame(txFrame), .linkEvents(linkEvents),
    .txLinkBit(txLinkBit), .txSaBit(txSaBit), .txSaSelect(txSaSelect), .irq(irq));
  fes_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] nextRand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nextRand
  function automatic logic irqExp();
    return ((expStat3 & mask3) | (expStat4 & mask4)) != 0;
  endfunction : irqExp
  task automatic checkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : checkVal
  task automatic regWr(input logic [7:0] ix, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    host.xfer(1'b1, ix, wd, rd, err);
  endtask : regWr
  // Reading a status register clears the model copy as well
  task automatic regRd(input logic [7:0] ix, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic err;
    host.xfer(1'b0, ix, 32'h0, rd, err);
    checkVal("prdata", exp, rd);
    checkVal("pslverr", 32'(expErr), 32'(err));
    if (ix == FES_IDX_STAT4) expStat4 = 0;
    if (ix == FES_IDX_STAT3) expStat3 = 0;
  endtask : regRd
  // One frame on both directions, plus the reference model of status four
  task automatic frame(input logic [7:0] ts);
    int pos;
    logic [4:0] sa;
    pos = idx % mfLen;
    // Message bits ride Sa6 in odd frames, MSB first in each half
    sa = (pos % 2) ? {5{ssmRx[3 - (pos % 8) / 2]}} & 5'h04 : 5'h00;
    @(posedge clk);
    rxFrame <= '{1'b1, pos == 0, ts, sa};
    txFrame <= '{1'b1, pos == 0, 1'b0};
    @(posedge clk);
    rxFrame <= '0;
    txFrame <= '0;
    if (e1) begin
      if (pos == 0) begin
        if (idx > 0 && zeroMf) expStat4 |= 32'h20;
        zeroMf = 1'b1;
        expStat4 |= 32'h16;
      end
      if (pos % 2 == 0) expStat4 |= 32'h09;
      if (ts != 8'h00) zeroMf = 1'b0;
      winZeros += 8 - $countones(ts);
      if (idx % 16 == 15) begin
        if (winZeros < 3) expStat4 |= 32'h40;
        winZeros = 0;
      end
    end else if (pos == 0) begin
      expStat4 |= 32'h14;
    end
    idx++;
  endtask : frame
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // Watchdog sized well above the few hundred cycles of the tests
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    conclude();
  end
  // Main sequence
  initial begin
    logic [31:0] b, ev;
    seed = 32'd68;
    rst_b = 1'b0;
    ce = 1'b1;
    rxFrame = '0;
    txFrame = '0;
    linkEvents = 8'h00;
    {expStat3, expStat4, mask3, mask4, idx, winZeros} = '0;
    zeroMf = 1'b0;
    ssmRx = 4'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    regRd(FES_IDX_STAT4, 32'h0, 1'b0);
    regRd(FES_IDX_MASK4, 32'h0, 1'b0);
    regRd(FES_IDX_MASK3, 32'h0, 1'b0);
    regRd(FES_IDX_TXLINK, 32'h0, 1'b0);
    regRd(8'h00, 32'h0, 1'b1);
    $display("test reset done");
    regWr(FES_IDX_CTRL, 32'h03);
    e1 = 1'b1;
    mfLen = 16;
    repeat (16) frame(8'hFF);
    repeat (17) frame(8'h00);
    regWr(FES_IDX_MASK4, 32'hFF);
    mask4 = 32'h7F;
    regRd(FES_IDX_MASK4, 32'h7F, 1'b0);
    checkVal("irq", 32'(irqExp()), 32'(irq));
    regRd(FES_IDX_STAT4, 32'(expStat4), 1'b0);
    @(posedge clk);
    #1 checkVal("irq", 32'(irqExp()), 32'(irq));
    repeat (16) frame(8'h00);
    regRd(FES_IDX_STAT4, 32'(expStat4), 1'b0);
    $display("test e1 events done");
    for (int s = 0; s < 5; s++) begin
      regWr(FES_IDX_CTRL, 32'h01 | (32'(s) << 4));
      @(posedge clk);
      #1 checkVal("txSaSelect", 32'h1 << s, 32'(txSaSelect));
    end
    for (int m = 0; m < 2; m++) begin
      regWr(FES_IDX_CTRL, m ? 32'h04 : 32'h00);
      e1 = 1'b0;
      idx = 0;
      mfLen = m ? 24 : 12;
      repeat (mfLen + 1) frame(8'hFF);
      regRd(FES_IDX_STAT4, 32'(expStat4), 1'b0);
    end
    $display("test t1 events done");
    regWr(FES_IDX_MASK4, 32'h00);
    mask4 = 0;
    for (int k = 0; k < 3; k++) begin
      mask3 = 32'(nextRand() & 32'hFF);
      ev = nextRand() & 32'hFF;
      regWr(FES_IDX_MASK3, 32'(mask3));
      regRd(FES_IDX_MASK3, 32'(mask3), 1'b0);
      @(posedge clk);
      linkEvents <= ev[7:0];
      @(posedge clk);
      linkEvents <= 8'h00;
      expStat3 |= 32'(ev);
      @(posedge clk);
      #1 checkVal("irq", 32'(irqExp()), 32'(irq));
      regRd(FES_IDX_STAT3, 32'(expStat3), 1'b0);
      @(posedge clk);
      #1 checkVal("irq", 32'(irqExp()), 32'(irq));
    end
    $display("test interrupt done");
    for (int k = 0; k < 2; k++) begin
      b = nextRand() & 32'hFF;
      regWr(FES_IDX_TXLINK, b);
      regRd(FES_IDX_TXLINK, b, 1'b0);
      for (int i = 0; i < 8; i++) begin
        @(posedge clk);
        txFrame <= '{1'b0, 1'b0, 1'b1};
        @(posedge clk);
        txFrame <= '0;
        #1 checkVal("txLinkBit", 32'(b[i]), 32'(txLinkBit));
      end
    end
    $display("test link byte done");
    // E1 with CRC4, message on Sa6: three equal halves validate the code
    regWr(FES_IDX_CTRL, 32'h23);
    regWr(FES_IDX_SSMTX, 32'(FES_SSM_SETS));
    e1 = 1'b1;
    idx = 0;
    mfLen = 16;
    ssmRx = FES_SSM_SETS;
    for (int f = 0; f < 32; f++) begin
      frame(8'hFF);
      if (f % 2 == 1) begin
        #1 checkVal("txSaBit", 32'(FES_SSM_SETS[3 - (f % 8) / 2]), 32'(txSaBit));
      end
    end
    regRd(FES_IDX_SSMRX, {19'h0, 5'h04, 3'h0, 1'b1, FES_SSM_SETS}, 1'b0);
    // Double-frame access snapshots the Sa bits of every odd frame
    regWr(FES_IDX_CTRL, 32'h2B);
    ssmRx = FES_SSM_SSUA;
    repeat (2) frame(8'hFF);
    regRd(FES_IDX_SSMRX, {19'h0, 5'h00, 3'h0, 1'b1, FES_SSM_SETS}, 1'b0);
    $display("test status message done");
    conclude();
  end
endmodule : tb_top
bind fes_event_status fes_event_status_props chk (.clk(clk), .rst_b(rst_b), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxFrame(rxFrame),
  .txFrame(txFrame), .linkEvents(linkEvents), .txLinkBit(txLinkBit), .irq(irq));
